// ---- rtl/cils_top.sv ----
// camera i/o line status: gpio direction, per-line level and all-lines word
// assumes a master that never issues read and write together
// How it works
// R1 - after reset the gpio line is an input
// R2 - software sets gpio direction to input or output
// R3 - gpio line is addressed as line index 3
// R4 - status flag reads selected line level, one for high
// R5 - software reads output level by selecting line 2 then reading status
// R6 - all-lines word is 32 bits, bit one means line high
// R7 - one read returns all line levels sampled together
// R8 - line n sits at bit n, unused bits read zero
//
// The plain strobed port and the address map were chosen for this implementation.
module cils_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic        IN_LINE,
   output logic             OUT_LINE,
   input  wire logic        GPIO_I,
   output logic             GPIO_O,
   output logic             GPIO_OE
);
   // ==========================================
   // register port
   cils_pkg::cils_req_t req;
   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   logic [1:0] line_sel;
   logic       gpio_mode;
   logic [1:0] out_val;
   logic [2:0] lvl;
   logic [31:0] next_rdata;

   wire hit_sel    = req.addr == cils_pkg::CILS_OFF_SELECT;
   wire hit_mode   = req.addr == cils_pkg::CILS_OFF_MODE;
   wire hit_status = req.addr == cils_pkg::CILS_OFF_STATUS;
   wire hit_all    = req.addr == cils_pkg::CILS_OFF_ALL;
   wire hit_outval = req.addr == cils_pkg::CILS_OFF_OUTVAL;
   wire hit_any    = hit_sel || hit_mode || hit_status || hit_all || hit_outval;
   // R3 gpio line index
   wire sel_gpio   = line_sel == cils_pkg::CILS_LINE_GPIO;

   // ==========================================
   // settings registers

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         line_sel <= cils_pkg::CILS_SELECT_RESET;
      end else if (req.wr && hit_sel) begin
         line_sel <= req.wdata[1:0];
      end
   end

   // R1 default selection
   sel_reset_a : assert property (@(posedge SYS_CLK) RST |=> line_sel == cils_pkg::CILS_SELECT_RESET) // R1
      else $error("line selector not at its reset value");

   // R3 selector write
   sel_write_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R3
      (req.wr && hit_sel) |=> line_sel == $past(req.wdata[1:0]))
      else $error("line selector not updated");

   // R1 input after reset
   // R2 direction write
   // mode writes act only on the gpio line; the others have fixed direction
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         gpio_mode <= cils_pkg::CILS_MODE_INPUT;
      end else if (req.wr && hit_mode && sel_gpio) begin
         gpio_mode <= req.wdata[0];
      end
   end

   // R2 input never sinks
   oe_input_a : assert property (@(posedge SYS_CLK) // R2
      gpio_mode == cils_pkg::CILS_MODE_INPUT |-> !GPIO_OE)
      else $error("gpio driven while set as input");

   // bit 0 drives the output line, bit 1 the gpio when it is an output
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         out_val <= {cils_pkg::CILS_OUTVAL_RESET, cils_pkg::CILS_OUTVAL_RESET};
      end else if (req.wr && hit_outval) begin
         out_val <= req.wdata[1:0];
      end
   end

   // R2 drive value write
   drive_write_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.wr && hit_outval) |=> OUT_LINE == $past(req.wdata[0]))
      else $error("output line not updated");

   // R2 unmapped write ignored
   wr_unmapped_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.wr && !hit_any) |=> $stable(line_sel) && $stable(gpio_mode) && $stable(out_val))
      else $error("unmapped write changed a setting");

   assign OUT_LINE = out_val[0];
   // open collector: only pulls low, so enable while output and driving low
   assign GPIO_O   = 1'b0;
   assign GPIO_OE  = (gpio_mode == cils_pkg::CILS_MODE_OUTPUT) && !out_val[1];

   // ==========================================
   // line levels; the output line is read back from its own drive
   logic [1:0] raw_sync;
   cils_sync u_sync (
      .clk  (SYS_CLK),
      .rst  (RST),
      .din  ({GPIO_I, IN_LINE, OUT_LINE}),
      .dout (lvl)
   );
   assign raw_sync = lvl[2:1];

   // R7 two-cycle sampling delay
   // the synced copy of the output line is watched only here, as a check on that delay
   sync_delay_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R7
      (!$past(RST) && !$past(RST, 2)) |-> lvl[0] == $past(OUT_LINE, 2))
      else $error("line sampling delay wrong");

   // ==========================================
   // all-lines word
   // index 0 names no line, so its bit is zero
   wire [cils_pkg::CILS_LINE_GPIO:0] line_level = {raw_sync[1], out_val[0], raw_sync[0], 1'b0};
   wire [31:0]                       all_word;
   // R8 line n at bit n
   for (genvar bit_idx = 0; bit_idx < 32; bit_idx++) begin : g_all_bit
      if (bit_idx <= cils_pkg::CILS_LINE_GPIO) begin : g_line
         assign all_word[bit_idx] = line_level[bit_idx];
      end else begin : g_unused
         assign all_word[bit_idx] = 1'b0;
      end
   end
   // R4 selected line level
   // R5 line 2 reads its driven level
   wire sel_level = (line_sel == cils_pkg::CILS_LINE_INPUT)  ? raw_sync[0] :
                    (line_sel == cils_pkg::CILS_LINE_OUTPUT) ? out_val[0] :
                    sel_gpio ? raw_sync[1] : 1'b0;

   wire [31:0] mode_word = {31'h00000000, sel_gpio ? gpio_mode :
                           (line_sel == cils_pkg::CILS_LINE_OUTPUT)};

   // ==========================================
   // read data
   // R6 32-bit word
   // R7 all lines in one read
   assign next_rdata = !req.rd     ? 32'h00000000 :
                       hit_sel     ? {30'h00000000, line_sel} :
                       hit_mode    ? mode_word :
                       hit_status  ? {31'h00000000, sel_level} :
                       hit_all     ? all_word :
                       hit_outval  ? {30'h00000000, out_val} :
                       cils_pkg::CILS_UNMAPPED;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         RDATA <= 32'h00000000;
      end else begin
         RDATA <= next_rdata;
      end
   end

   // ==========================================
   // checks
   // R1 reset direction
   reset_input_a : assert property (@(posedge SYS_CLK) RST |=> !GPIO_OE) // R1
      else $error("gpio not input after reset");
   // R2 direction write
   dir_write_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.wr && hit_mode && sel_gpio) |=> gpio_mode == $past(req.wdata[0]))
      else $error("gpio direction not updated");
   // R2 direction readback
   mode_read_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.rd && hit_mode && sel_gpio) |=> RDATA == {31'h00000000, $past(gpio_mode)})
      else $error("gpio direction readback wrong");
   // R2 output line reads as an output
   out_mode_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.rd && hit_mode && line_sel == cils_pkg::CILS_LINE_OUTPUT) |=> RDATA[0] == cils_pkg::CILS_MODE_OUTPUT)
      else $error("output line direction readback wrong");
   // R3 index 3 only
   gpio_index_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R3
      (req.wr && hit_mode && !sel_gpio) |=> $stable(gpio_mode))
      else $error("non-gpio selection changed gpio direction");
   // R4 status read
   status_read_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R4
      (req.rd && hit_status) |=> RDATA == {31'h00000000, $past(sel_level)})
      else $error("status flag wrong");
   // R4 input line flag
   in_status_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R4
      (req.rd && hit_status && line_sel == cils_pkg::CILS_LINE_INPUT) |=> RDATA[0] == $past(lvl[1]))
      else $error("input line flag wrong");
   // R4 gpio line flag
   gpio_status_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R4
      (req.rd && hit_status && sel_gpio) |=> RDATA[0] == $past(lvl[2]))
      else $error("gpio line flag wrong");
   // R5 output readback
   out_readback_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R5
      (req.rd && hit_status && line_sel == cils_pkg::CILS_LINE_OUTPUT) |=> RDATA[0] == OUT_LINE)
      else $error("output line readback wrong");
   // R6 unused bits zero
   all_upper_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R6
      (req.rd && hit_all) |=> RDATA[31:4] == 28'h0000000 && RDATA[0] == 1'b0)
      else $error("all-lines upper bits not zero");
   // R7 same sample
   all_sample_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R7
      (req.rd && hit_all) |=> RDATA[3:1] == $past({lvl[2], OUT_LINE, lvl[1]}))
      else $error("all-lines word not one sample");
   // R8 bit positions
   bit_place_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R8
      (req.rd && hit_all) |=> RDATA[2] == $past(OUT_LINE))
      else $error("output line bit misplaced");
   unmapped_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R6
      (req.rd && !hit_any) |=> RDATA == 32'h00000000)
      else $error("unmapped read not zero");
   // R6 read data only after a read
   // a zero between reads keeps a stale word from being taken twice
   idle_rdata_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R6
      !req.rd |=> RDATA == 32'h00000000)
      else $error("read data not zero outside a read");
   // R2 drive value readback
   drive_read_a : assert property (@(posedge SYS_CLK) disable iff (RST) // R2
      (req.rd && hit_outval) |=> RDATA == {30'h00000000, $past(out_val)})
      else $error("drive value readback wrong");
endmodule : cils_top

// ---- rtl/cils_pkg.sv ----
// package for the camera i/o line status block: register map, line indices, fields
// assumes a single 125 MHz clock and a simple strobe register port
package cils_pkg;
   // ==========================================
   // register offsets (byte addresses)
   localparam logic [7:0] CILS_OFF_SELECT   = 8'h00;
   localparam logic [7:0] CILS_OFF_MODE     = 8'h04;
   localparam logic [7:0] CILS_OFF_STATUS   = 8'h08;
   localparam logic [7:0] CILS_OFF_ALL      = 8'h0C;
   localparam logic [7:0] CILS_OFF_OUTVAL   = 8'h10;
   // ==========================================
   // line indices
   localparam logic [1:0] CILS_LINE_INPUT   = 2'h1;
   localparam logic [1:0] CILS_LINE_OUTPUT  = 2'h2;
   localparam logic [1:0] CILS_LINE_GPIO    = 2'h3;
   localparam int         CILS_NUM_LINES    = 3;
   // ==========================================
   // resets and fields
   localparam logic [1:0] CILS_SELECT_RESET = 2'h1;
   localparam logic       CILS_MODE_INPUT   = 1'b0;
   localparam logic       CILS_MODE_OUTPUT  = 1'b1;
   localparam logic       CILS_OUTVAL_RESET = 1'b0;
   localparam logic [31:0] CILS_UNMAPPED    = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } cils_req_t;
endpackage : cils_pkg

// ---- rtl/cils_sync.sv ----
// two-flop synchroniser for the external line levels
// assumes the lines are asynchronous to SYS_CLK
module cils_sync (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [cils_pkg::CILS_NUM_LINES-1:0] din,
   output logic      [cils_pkg::CILS_NUM_LINES-1:0] dout
);
   logic [cils_pkg::CILS_NUM_LINES-1:0] stage1;
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule : cils_sync

// ---- test/cils_line_model.sv ----
// far-side circuitry on the gpio pin: an optional external driver plus pull-up
// assumes the device side is open collector, sinking only while enabled
module cils_line_model (
   input  wire logic gpio_o,
   input  wire logic gpio_oe,
   input  wire logic ext_en,
   input  wire logic ext_val,
   output logic      gpio_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // wire level
   // sinking wins; with nobody driving, the pull-up shows a high
   assign gpio_i = (gpio_oe && !gpio_o) ? 1'b0 : (ext_en ? ext_val : 1'b1);
endmodule : cils_line_model

// ---- test/tb_top.sv ----
// self-checking bench for the camera i/o line status block
// assumes the strobe register port and a 2-cycle line synchroniser
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, wr, rd, in_line, ext_en, ext_val;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic        out_line, gpio_i, gpio_o, gpio_oe;
   int          error_cnt = 0;
   int          checked = 0;
   cils_top cils_top_inst (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IN_LINE(in_line), .OUT_LINE(out_line), .GPIO_I(gpio_i), .GPIO_O(gpio_o),
      .GPIO_OE(gpio_oe));
   cils_line_model cils_line_model_inst (.gpio_o(gpio_o), .gpio_oe(gpio_oe), .ext_en(ext_en),
      .ext_val(ext_val), .gpio_i(gpio_i));
   // ==========================================
   // bus and compare tasks
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   // ==========================================
   // scenarios
   task automatic t_gpio();
      #1 check({31'h0, gpio_oe}, 32'h0);
      wreg(cils_pkg::CILS_OFF_SELECT, 32'h3);
      rreg(cils_pkg::CILS_OFF_MODE); check(d, 32'h0);
      wreg(cils_pkg::CILS_OFF_MODE, 32'h1); settle(); check({31'h0, gpio_oe}, 32'h1);
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h0);
      wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h2); settle(); check({31'h0, gpio_oe}, 32'h0);
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h1);
      wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h0);
      wreg(cils_pkg::CILS_OFF_MODE, 32'h0); ext_en <= 1'b1; settle();
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h0);
      // a mode write to a line other than the gpio must not turn it round
      wreg(cils_pkg::CILS_OFF_SELECT, 32'h1); wreg(cils_pkg::CILS_OFF_MODE, 32'h1);
      #1 check({31'h0, gpio_oe}, 32'h0);
      rreg(cils_pkg::CILS_OFF_MODE); check(d, 32'h0);
      $display("test gpio done");
   endtask : t_gpio
   task automatic t_outline();
      wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h1); #1 check({31'h0, out_line}, 32'h1);
      // select line 2, set output, then read
      wreg(cils_pkg::CILS_OFF_SELECT, 32'h2); wreg(cils_pkg::CILS_OFF_MODE, 32'h1);
      rreg(cils_pkg::CILS_OFF_MODE); check(d, {31'h0, cils_pkg::CILS_MODE_OUTPUT});
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h1);
      wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h0);
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h0);
      $display("test output line done");
   endtask : t_outline
   task automatic t_all();
      @(posedge clk); in_line <= 1'b1; ext_val <= 1'b1; wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h1); settle();
      rreg(cils_pkg::CILS_OFF_ALL); check(d, 32'h0000_000E);
      @(posedge clk); in_line <= 1'b0; wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h0); settle();
      rreg(cils_pkg::CILS_OFF_ALL); check(d, 32'h0000_0008);
      @(posedge clk); ext_val <= 1'b0; in_line <= 1'b1; settle();
      rreg(cils_pkg::CILS_OFF_ALL); check(d, 32'h0000_0002);
      rreg(8'h20); check(d, 32'h0000_0000);
      // an unmapped write must leave every setting alone
      wreg(8'h20, 32'hFFFF_FFFF); rreg(cils_pkg::CILS_OFF_ALL); check(d, 32'h0000_0002);
      rreg(cils_pkg::CILS_OFF_SELECT); check(d, 32'h2);
      $display("test all lines done");
   endtask : t_all
   task automatic t_reset();
      wreg(cils_pkg::CILS_OFF_SELECT, 32'h3); wreg(cils_pkg::CILS_OFF_MODE, 32'h1);
      wreg(cils_pkg::CILS_OFF_OUTVAL, 32'h1);
      #1 check({31'h0, gpio_oe}, 32'h1);
      // reset in mid-run must return the gpio to an input
      @(posedge clk); rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1 check({31'h0, gpio_oe}, 32'h0);
      check({31'h0, out_line}, {31'h0, cils_pkg::CILS_OUTVAL_RESET});
      rreg(cils_pkg::CILS_OFF_SELECT); check(d, {30'h0, cils_pkg::CILS_SELECT_RESET});
      rreg(cils_pkg::CILS_OFF_STATUS); check(d, 32'h1);
      wreg(cils_pkg::CILS_OFF_SELECT, 32'h3);
      rreg(cils_pkg::CILS_OFF_MODE); check(d, {31'h0, cils_pkg::CILS_MODE_INPUT});
      rreg(cils_pkg::CILS_OFF_OUTVAL);
      check(d, {30'h0, cils_pkg::CILS_OUTVAL_RESET, cils_pkg::CILS_OUTVAL_RESET});
      $display("test reset done");
   endtask : t_reset
   // ==========================================
   // clock, watchdog, main sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      in_line = 1'b0; ext_en = 1'b0; ext_val = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_gpio();
      t_outline();
      t_all();
      t_reset();
      print_verdict();
   end
endmodule : tb_top
